// *** design/ise_top.sv ***
// two-wire slave front end of the presence-detect eeprom
//
// Operation
// - 256 byte locations reached by an 8-bit internal address.
// - protect command permanently locks writes to the lower 128 bytes.
// - write guard high refuses every write to the whole array.
// - select type 1010 reaches the array, 0110 the protect register.
// - select bits b3..b1 must equal the three bus select inputs.
// - every byte moves most significant bit first.
// - device acknowledges received bytes in the ninth bit period.
// - random read: write select, address, repeated START, read select.
// - sequential reads return consecutive bytes while master keeps acknowledging.
// - single byte or page of up to 16 bytes per write.
// - programming runs on internal timing, no serial clocks needed.
// - direction bit one means read, zero means write.
// - mismatching select byte gets no acknowledge; device goes standby.
// - programming starts only when STOP ends a write command.
// - data line sampled on each rising serial clock edge.
`timescale 1ns/1ps
`default_nettype none
module ise_top
   import ise_pkg::*;
#(
   parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
   input  wire logic            clk_sys_i,
   input  wire logic            rst_n_i,
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   input  wire logic [CE_W-1:0] bus_select_inputs_i,
   input  wire logic            write_guard_input_i,
   output logic                 sda_o,
   output logic                 sda_oe_o,
   output logic                 prog_busy_o,
   output logic                 low_half_locked_o
);
   localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES_P - 1);

   // bus condition toggles, clocked by the data line
   logic start_tgl_q;
   logic stop_tgl_q;
   // link domain
   ise_link_state_type state_q;
   logic [2:0]        bit_cnt_q;
   logic [DATA_W-1:0] rx_q;
   logic [DATA_W-1:0] tx_q;
   logic [ADDR_W-1:0] addr_q;
   logic              ack_q;
   logic              is_read_q;
   logic              is_prot_q;
   logic              start_seen_q;
   logic [DATA_W-1:0] page_buf_q [PAGE_SIZE];
   logic [PAGE_SIZE-1:0] buf_mask_q;
   logic [PAGE_W-1:0] page_q;
   logic              pend_wr_q;
   logic              pend_lock_q;
   logic [CE_W-1:0]   ce_l;
   logic              wg_l;
   logic              busy_l;
   logic              lock_l;
   // system domain
   ise_prog_state_type prog_state_q;
   logic [PAGE_W-1:0]  idx_q;
   logic [PROG_CNT_W-1:0] timer_q;
   logic              lock_q;
   logic              busy_q;
   logic              stop_s;
   logic              stop_prev_q;
   logic              wg_s;
   logic              pend_wr_s;
   logic              pend_lock_s;
   logic [DATA_W-1:0] rd_data;
   logic              mem_wr_en;
   logic [ADDR_W-1:0] mem_wr_addr;

   // decode of the current bit
   logic              start_now;
   logic              byte_done;
   logic [DATA_W-1:0] rx_byte;
   logic              sel_ok;
   logic              data_ok;
   logic              stop_evt;
   logic              go_prog;
   logic              prog_done;
   logic              drive_low;

   // -------- bus conditions: data edge while clock is high --------
   always_ff @(negedge sda_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_tgl_q <= 1'b0;
      end else if (scl_i) begin
         start_tgl_q <= ~start_tgl_q;
      end
   end

   always_ff @(posedge sda_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_tgl_q <= 1'b0;
      end else if (scl_i) begin
         stop_tgl_q <= ~stop_tgl_q;
      end
   end

   // pins and system levels brought onto the serial clock
   ise_sync #(.WIDTH(CE_W + 3)) u_sync_link (
      .clk_i   (scl_i),
      .rst_n_i (rst_n_i),
      .d_i     ({bus_select_inputs_i, write_guard_input_i, busy_q, lock_q}),
      .q_o     ({ce_l, wg_l, busy_l, lock_l})
   );

   // start toggle flips only while the clock is high, so it is settled
   // a full low phase before the next rising edge reads it
   assign start_now = start_tgl_q ^ start_seen_q;
   assign byte_done = (bit_cnt_q == BIT_LAST);
   assign rx_byte   = {rx_q[DATA_W-2:0], sda_i};

   // select acceptance
   always_comb begin
      sel_ok = 1'b0;
      if (rx_byte[CE_W:1] == ce_l && !busy_l) begin
         if (rx_byte[7:4] == TYPE_ARRAY) begin
            sel_ok = 1'b1;
         end else if (rx_byte[7:4] == TYPE_PROTECT) begin
            sel_ok = (rx_byte[0] == DIR_READ) || (!wg_l && !lock_l);
         end
      end
   end

   // data byte acceptance
   always_comb begin
      data_ok = !wg_l;
      if (!is_prot_q && lock_l && ise_is_low_half(addr_q)) begin
         data_ok = 1'b0;
      end
   end

   // -------- link state, sampled on the rising serial clock --------
   // all reception on rising edges
   always_ff @(posedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q      <= LS_IDLE;
         bit_cnt_q    <= '0;
         start_seen_q <= 1'b0;
         ack_q        <= 1'b0;
      end else if (start_now) begin
         start_seen_q <= start_tgl_q;
         state_q      <= LS_SEL;
         bit_cnt_q    <= 3'h1;
         ack_q        <= 1'b0;
      end else begin
         bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
         unique case (state_q)
            LS_IDLE: begin
               bit_cnt_q <= '0;
            end
            LS_SEL: begin
               if (byte_done) begin
                  // no ack on mismatch, back to standby
                  state_q <= sel_ok ? LS_SEL_ACK : LS_IDLE;
                  ack_q   <= sel_ok;
               end
            end
            LS_SEL_ACK: begin
               bit_cnt_q <= '0;
               ack_q     <= 1'b0;
               state_q   <= is_read_q ? LS_READ : LS_ADDR;
            end
            LS_ADDR: begin
               if (byte_done) begin
                  state_q <= LS_ADDR_ACK;
                  ack_q   <= 1'b1;
               end
            end
            LS_ADDR_ACK, LS_DATA_ACK: begin
               bit_cnt_q <= '0;
               ack_q     <= 1'b0;
               state_q   <= LS_DATA;
            end
            LS_DATA: begin
               if (byte_done) begin
                  state_q <= LS_DATA_ACK;
                  ack_q   <= data_ok;
               end
            end
            LS_READ: begin
               if (byte_done) begin
                  state_q <= LS_READ_ACK;
               end
            end
            LS_READ_ACK: begin
               bit_cnt_q <= '0;
               state_q   <= sda_i ? LS_IDLE : LS_READ;
            end
         endcase
      end
   end

   // receive shift and command kind
   always_ff @(posedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_q      <= '0;
         is_read_q <= 1'b0;
         is_prot_q <= 1'b0;
      end else begin
         rx_q <= start_now ? {{(DATA_W-1){1'b0}}, sda_i} : rx_byte;
         if (state_q == LS_SEL && byte_done && !start_now) begin
            is_read_q <= (rx_byte[0] == DIR_READ);
            is_prot_q <= (rx_byte[7:4] == TYPE_PROTECT);
         end
      end
   end

   // transmit shift and address counter
   always_ff @(posedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_q   <= ERASED_BYTE;
         addr_q <= '0;
      end else if (!start_now) begin
         if ((state_q == LS_SEL_ACK && is_read_q) ||
             (state_q == LS_READ_ACK && !sda_i)) begin
            tx_q <= is_prot_q ? {STATUS_PAD, lock_l} : rd_data;
            if (!is_prot_q) begin
               addr_q <= ise_next_addr(addr_q);
            end
         end else if (state_q == LS_READ) begin
            tx_q <= {tx_q[DATA_W-2:0], 1'b0};
         end else if (state_q == LS_ADDR && byte_done && !is_prot_q) begin
            addr_q <= rx_byte;
         end else if (state_q == LS_DATA && byte_done && data_ok && !is_prot_q) begin
            addr_q <= {addr_q[ADDR_W-1:PAGE_W], PAGE_W'(addr_q[PAGE_W-1:0] + 1'b1)};
         end
      end
   end

   // page buffer collected over the link, drained after stop
   always_ff @(posedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < PAGE_SIZE; i++) begin
            page_buf_q[i] <= ERASED_BYTE;
         end
         buf_mask_q  <= '0;
         page_q      <= '0;
         pend_wr_q   <= 1'b0;
         pend_lock_q <= 1'b0;
      end else if (start_now) begin
         buf_mask_q  <= '0;
         pend_wr_q   <= 1'b0;
         pend_lock_q <= 1'b0;
      end else if (state_q == LS_DATA && byte_done && data_ok) begin
         if (is_prot_q) begin
            pend_lock_q <= 1'b1;
         end else begin
            // up to one page per transfer
            page_buf_q[addr_q[PAGE_W-1:0]] <= rx_byte;
            buf_mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
            page_q    <= addr_q[ADDR_W-1:PAGE_W];
            pend_wr_q <= 1'b1;
         end
      end
   end

   // -------- data line drive, changed on the falling serial clock --------
   assign drive_low = ((state_q == LS_SEL_ACK || state_q == LS_ADDR_ACK ||
                        state_q == LS_DATA_ACK) && ack_q) ||
                      (state_q == LS_READ && !tx_q[DATA_W-1]);

   // open drain: only ever pull low, released otherwise
   always_ff @(negedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_oe_o <= 1'b0;
         sda_o    <= 1'b0;
      end else begin
         // ack driven through the ninth bit
         sda_oe_o <= drive_low;
         sda_o    <= 1'b0;
      end
   end

   // -------- system domain: self-timed programming --------
   ise_sync #(.WIDTH(4)) u_sync_sys (
      .clk_i   (clk_sys_i),
      .rst_n_i (rst_n_i),
      .d_i     ({stop_tgl_q, write_guard_input_i, pend_wr_q, pend_lock_q}),
      .q_o     ({stop_s, wg_s, pend_wr_s, pend_lock_s})
   );

   // stop event from the synchronised toggle
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_prev_q <= 1'b0;
      end else begin
         stop_prev_q <= stop_s;
      end
   end

   assign stop_evt  = stop_s ^ stop_prev_q;
   // only a stop after a write command
   assign go_prog   = (prog_state_q == PS_IDLE) && stop_evt && !wg_s &&
                      (pend_wr_s || pend_lock_s);
   assign prog_done = (prog_state_q == PS_WAIT) && (timer_q == PROG_LAST);

   // sequencing on the system clock only
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prog_state_q <= PS_IDLE;
         idx_q        <= '0;
         timer_q      <= '0;
      end else begin
         unique case (prog_state_q)
            PS_IDLE: begin
               idx_q   <= '0;
               timer_q <= '0;
               if (go_prog) begin
                  prog_state_q <= PS_COPY;
               end
            end
            PS_COPY: begin
               idx_q <= PAGE_W'(idx_q + 1'b1);
               if (idx_q == IDX_LAST) begin
                  prog_state_q <= PS_WAIT;
               end
            end
            PS_WAIT: begin
               timer_q <= PROG_CNT_W'(timer_q + 1'b1);
               if (prog_done) begin
                  prog_state_q <= PS_IDLE;
               end
            end
         endcase
      end
   end

   // busy flag seen by the link and the pin
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
      end else if (go_prog) begin
         busy_q <= 1'b1;
      end else if (prog_done) begin
         busy_q <= 1'b0;
      end
   end

   // lock is set once and never cleared
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_q <= 1'b0;
      end else if (go_prog && pend_lock_s) begin
         lock_q <= 1'b1;
      end
   end

   // exported status
   assign prog_busy_o       = busy_q;
   assign low_half_locked_o = lock_q;

   // buffer is stable here: the serial clock is idle after stop
   assign mem_wr_addr = {page_q, idx_q};
   assign mem_wr_en   = (prog_state_q == PS_COPY) && buf_mask_q[idx_q] && !wg_s &&
                        !(lock_q && ise_is_low_half(mem_wr_addr));

   ise_mem u_mem (
      .clk_i     (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .wr_en_i   (mem_wr_en),
      .wr_addr_i (mem_wr_addr),
      .wr_data_i (page_buf_q[idx_q]),
      .rd_addr_i (addr_q),
      .rd_data_o (rd_data)
   );

   // -------- checks on the link domain --------
   AST_SEL_TYPE_NAK: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_SEL && byte_done && !start_now &&
       rx_byte[7:4] != TYPE_ARRAY && rx_byte[7:4] != TYPE_PROTECT)
      |=> (state_q == LS_IDLE && !ack_q))
      else $error("bad type code was acknowledged");

   AST_CE_MISMATCH: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_SEL && byte_done && !start_now && rx_byte[CE_W:1] != ce_l)
      |=> !ack_q ##1 !sda_oe_o[*1])
      else $error("foreign select code was acknowledged");

   AST_ADDR_ACK: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_ADDR && byte_done && !start_now)
      |=> (state_q == LS_ADDR_ACK && ack_q) ##1 (state_q == LS_DATA || $past(start_now)))
      else $error("address byte not acknowledged in ninth period");

   AST_MSB_FIRST: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_READ && !byte_done && !start_now)
      |=> tx_q[DATA_W-1] == $past(tx_q[DATA_W-2]))
      else $error("read data not shifted msb first");

   AST_DIR_READ: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_SEL_ACK && !start_now)
      |=> (state_q == (is_read_q ? LS_READ : LS_ADDR)))
      else $error("direction bit misread");

   AST_SEQ_STEP: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_READ_ACK && !sda_i && !start_now && !is_prot_q)
      |=> (addr_q == ise_next_addr($past(addr_q)) && state_q == LS_READ))
      else $error("sequential read did not advance");

   AST_PAGE_WRAP: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_DATA && byte_done && !start_now && !is_prot_q)
      |=> addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W]))
      else $error("page write left its page");

   AST_GUARD_NAK: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_DATA && byte_done && !start_now && wg_l)
      |=> (!ack_q && $stable(buf_mask_q)))
      else $error("write accepted while guard high");

   AST_LOCK_NAK: assert property (
      @(posedge scl_i) disable iff (!rst_n_i)
      (state_q == LS_DATA && byte_done && !start_now && !is_prot_q &&
       lock_l && ise_is_low_half(addr_q))
      |=> !ack_q)
      else $error("locked lower half write acknowledged");

   // -------- checks on the system domain --------
   AST_PROG_ON_STOP: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(busy_q) |-> $past(stop_evt) && $past(prog_state_q == PS_IDLE))
      else $error("programming began without a stop");

   AST_LOCK_STICKY: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      lock_q |=> lock_q)
      else $error("lower half lock was cleared");

   AST_PROG_SELF_TIMED: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (prog_state_q == PS_COPY && idx_q == IDX_LAST)
      |=> busy_q ##1 (prog_state_q == PS_WAIT))
      else $error("programming did not proceed on its own");

   COV_SEQ_READ: cover property (
      @(posedge scl_i) disable iff (!rst_n_i)
      state_q == LS_READ_ACK && !sda_i ##1 state_q == LS_READ);

   COV_PAGE_WRITE: cover property (
      @(posedge scl_i) disable iff (!rst_n_i)
      state_q == LS_DATA_ACK && ack_q && buf_mask_q[1] && buf_mask_q[0]);

   COV_LOCK_SET: cover property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(lock_q));
endmodule // ise_top
`default_nettype wire

// *** design/ise_pkg.sv ***
// shared constants, types and helpers of the presence-detect eeprom slave
package ise_pkg;

   // array geometry
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned MEM_DEPTH   = 256;
   localparam int unsigned PAGE_W      = 4;
   localparam int unsigned PAGE_SIZE   = 16;
   localparam int unsigned CE_W        = 3;
   localparam int unsigned LOW_HALF_BIT = 7;

   // select byte decode
   localparam logic [3:0] TYPE_ARRAY   = 4'hA;
   localparam logic [3:0] TYPE_PROTECT = 4'h6;
   localparam logic       DIR_READ     = 1'b1;
   localparam logic [2:0] BIT_LAST     = 3'h7;

   // stored and reported values
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
   localparam logic [6:0]        STATUS_PAD  = 7'h00;
   localparam logic [PAGE_W-1:0] IDX_LAST    = 4'hF;

   // self-timed programming cycle
   localparam int unsigned CLK_SYS_MHZ  = 100;
   localparam int unsigned PROG_TIME_US = 5000;
   localparam int unsigned PROG_CYCLES  = PROG_TIME_US * CLK_SYS_MHZ;
   localparam int unsigned PROG_CNT_W   = 20;

   typedef enum logic [3:0] {
      LS_IDLE, LS_SEL, LS_SEL_ACK, LS_ADDR, LS_ADDR_ACK,
      LS_DATA, LS_DATA_ACK, LS_READ, LS_READ_ACK
   } ise_link_state_type;

   typedef enum logic [1:0] {PS_IDLE, PS_COPY, PS_WAIT} ise_prog_state_type;

   // true for a location in the lockable lower half
   function automatic logic ise_is_low_half(input logic [ADDR_W-1:0] a);
      return ~a[LOW_HALF_BIT];
   endfunction

   // address step that rolls over the whole array
   function automatic logic [ADDR_W-1:0] ise_next_addr(input logic [ADDR_W-1:0] a);
      return ADDR_W'(a + 1'b1);
   endfunction

endpackage

// *** design/ise_sync.sv ***
// two-flop level synchroniser for a small vector
`timescale 1ns/1ps
`default_nettype none
module ise_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;

   // first stage is read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule // ise_sync
`default_nettype wire

// *** design/ise_mem.sv ***
// 256 x 8 storage array, clocked write, asynchronous read
`timescale 1ns/1ps
`default_nettype none
module ise_mem
   import ise_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              wr_en_i,
   input  wire logic [ADDR_W-1:0] wr_addr_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic [ADDR_W-1:0] rd_addr_i,
   output logic      [DATA_W-1:0] rd_data_o
);
   logic [DATA_W-1:0] cell_q [MEM_DEPTH];

   // array starts erased; written only by the programming cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            cell_q[i] <= ERASED_BYTE;
         end
      end else if (wr_en_i) begin
         cell_q[wr_addr_i] <= wr_data_i;
      end
   end

   // read is quasi-static: no writes while the link is serviced
   assign rd_data_o = cell_q[rd_addr_i];
endmodule // ise_mem
`default_nettype wire

// *** tb/ise_master.sv ***
// behavioural two-wire bus master that drives the serial clock and data
`timescale 1ns/1ps
`default_nettype none
module ise_master (
   output logic      scl_o,
   output logic      sda_drv_o,
   input  wire logic sda_i
);
   // idle bus: clock parked high, data released to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_drv_o = 1'b1;
   end
   // bit period of 6 ns; data moves only while the clock is low
   task automatic bit_out(input logic b);
      #1 sda_drv_o = b;
      #2 scl_o = 1'b1;
      #3 scl_o = 1'b0;
   endtask
   // slave's bit taken at the rising clock edge
   task automatic bit_in(output logic b);
      #1 sda_drv_o = 1'b1;
      #2 scl_o = 1'b1;
      b = sda_i;
      #3 scl_o = 1'b0;
   endtask
   // frame opening, also used as repeated start
   task automatic start();
      #1 sda_drv_o = 1'b1;
      #2 scl_o = 1'b1;
      #3 sda_drv_o = 1'b0;
      #3 scl_o = 1'b0;
   endtask
   // frame closing; clock then stands high
   task automatic stop();
      #1 sda_drv_o = 1'b0;
      #2 scl_o = 1'b1;
      #3 sda_drv_o = 1'b1;
      #3;
   endtask
   // msb first, then the acknowledge slot
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(a);
      ack = ~a;
   endtask
   // acknowledge each read byte except the last
   task automatic rbyte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(last);
   endtask
endmodule // ise_master
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the presence-detect eeprom slave
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ise_pkg::*;
   localparam int unsigned PROG_P = 20; // short programming cycle
   localparam logic [2:0]  CE     = 3'h5;
   logic       clk_sys_i, rst_n_i, guard, scl, sda_drv, sda_o, sda_oe, busy, locked, ack;
   logic [2:0] ce_pins; // bus select straps, moved once to prove the compare
   logic [7:0] rbuf [16];
   logic [7:0] bad [2] = '{{4'hB, CE, 1'b0}, {TYPE_ARRAY, ~CE, 1'b0}};
   int         error_cnt = 0;
   int         total_checks = 0;
   wire logic  sda = sda_drv & ~sda_oe; // open drain with pull-up

   ise_top #(.PROG_CYCLES_P(PROG_P)) u_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
      .bus_select_inputs_i(ce_pins), .write_guard_input_i(guard), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .prog_busy_o(busy), .low_half_locked_o(locked));
   ise_master u_mst (.scl_o(scl), .sda_drv_o(sda_drv), .sda_i(sda));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // busy sampled at falling edges, away from its own update
   task automatic wait_prog(input logic exp_busy);
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(8'(busy), 8'(exp_busy));
      while (busy !== 1'b0 && n < 200) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(8'(busy), 8'h00);
   endtask
   // write frame: select, word address, n bytes counting up from d0
   task automatic wr(input logic [3:0] ty, input logic [7:0] a, input logic [7:0] d0,
                     input int n, input logic exp_ack);
      repeat (3) @(posedge clk_sys_i);
      u_mst.start();
      u_mst.wbyte({ty, CE, 1'b0}, ack);
      chk(8'(ack), 8'h01);
      u_mst.wbyte(a, ack);
      for (int i = 0; i < n; i++) u_mst.wbyte(8'(d0 + i), ack);
      chk(8'(ack), 8'(exp_ack));
      chk(8'(busy), 8'h00);
      u_mst.stop();
      wait_prog(exp_ack);
      chk(8'(sda_o), 8'h00);
   endtask
   // random read of n bytes at a, or current read when cur is set
   task automatic rdn(input logic cur, input logic [7:0] a, input int n);
      repeat (3) @(posedge clk_sys_i);
      if (!cur) begin
         u_mst.start();
         u_mst.wbyte({TYPE_ARRAY, CE, 1'b0}, ack);
         u_mst.wbyte(a, ack);
      end
      u_mst.start();
      u_mst.wbyte({TYPE_ARRAY, CE, DIR_READ}, ack);
      chk(8'(ack), 8'h01);
      for (int i = 0; i < n; i++) u_mst.rbyte(i == n - 1, rbuf[i]);
      u_mst.stop();
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // watchdog: the sequence needs a few microseconds only
   initial begin
      #100000;
      error_cnt++;
      results();
   end
   initial begin
      rst_n_i = 1'b1;
      ce_pins = CE;
      guard = 1'b0;
      // a real falling edge once every process waits on it
      #1 rst_n_i = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      // byte write then random read back
      wr(TYPE_ARRAY, 8'h10, 8'h5A, 1, 1'b1);
      rdn(1'b0, 8'h10, 1);
      chk(rbuf[0], 8'h5A);
      // seventeen bytes: the last wraps onto slot 0 of the page
      wr(TYPE_ARRAY, 8'h20, 8'h00, 17, 1'b1);
      rdn(1'b0, 8'h20, 16);
      for (int i = 0; i < 16; i++) chk(rbuf[i], (i == 0) ? 8'h10 : 8'(i));
      // current read continues one past the last byte read
      rdn(1'b0, 8'h20, 2);
      rdn(1'b1, 8'h00, 1);
      chk(rbuf[0], 8'h02);
      // guard high: data refused, stored byte kept
      @(posedge clk_sys_i);
      guard <= 1'b1;
      wr(TYPE_ARRAY, 8'h10, 8'hC3, 1, 1'b0);
      @(posedge clk_sys_i);
      guard <= 1'b0;
      rdn(1'b0, 8'h10, 1);
      chk(rbuf[0], 8'h5A);
      // foreign type code and foreign bus select get no acknowledge
      foreach (bad[i]) begin
         u_mst.start();
         u_mst.wbyte(bad[i], ack);
         chk(8'(ack), 8'h00);
         u_mst.stop();
      end
      // straps moved: the formerly foreign code is now answered
      @(posedge clk_sys_i);
      ce_pins <= ~CE;
      u_mst.start();
      u_mst.wbyte(bad[1], ack);
      chk(8'(ack), 8'h01);
      u_mst.stop();
      @(posedge clk_sys_i);
      ce_pins <= CE;
      // protect command locks the lower half only
      chk(8'(locked), 8'h00);
      wr(TYPE_PROTECT, 8'h00, 8'h00, 1, 1'b1);
      chk(8'(locked), 8'h01);
      wr(TYPE_ARRAY, 8'h05, 8'h77, 1, 1'b0);
      wr(TYPE_ARRAY, 8'h85, 8'h77, 1, 1'b1);
      rdn(1'b0, 8'h05, 1);
      chk(rbuf[0], ERASED_BYTE);
      rdn(1'b0, 8'h85, 1);
      chk(rbuf[0], 8'h77);
      results();
   end
endmodule // tb
`default_nettype wire
